// *** logic/pllpd_defs.svh ***
// pllpd_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design files of the lock monitor
`ifndef PLLPD_DEFS_SVH
`define PLLPD_DEFS_SVH

// apb register byte offsets
`define PLLPD_ADDR_W         12
`define PLLPD_OFS_ENH        12'h000
`define PLLPD_OFS_STATUS     12'h004
`define PLLPD_OFS_IRQ_STAT   12'h008
`define PLLPD_OFS_IRQ_MASK   12'h00c

// enhancement register fields
`define PLLPD_ENH_W          8
`define PLLPD_ENH_REF_DIS    0
`define PLLPD_ENH_MAIN_DIS   1
`define PLLPD_ENH_AUX_SEL    2
`define PLLPD_ENH_RST        8'h00

// status register fields
`define PLLPD_ST_LOCKED      0
`define PLLPD_ST_NODE        1
`define PLLPD_ST_UP_N        2
`define PLLPD_ST_DOWN_N      3
`define PLLPD_ST_ENH_ACT     4
`define PLLPD_ST_SERIAL      5

// interrupt status and mask fields
`define PLLPD_IRQ_W          3
`define PLLPD_IRQ_LOCK_GAIN  0
`define PLLPD_IRQ_LOCK_LOSS  1
`define PLLPD_IRQ_ENH_LOAD   2
`define PLLPD_IRQ_RST        3'h0

// lock qualification time and its cycle count at 100 MHz
`define PLLPD_CLK_PERIOD_NS  10
`define PLLPD_LOCK_TIME_NS   1000
`define PLLPD_LOCK_CYCLES    ((`PLLPD_LOCK_TIME_NS + `PLLPD_CLK_PERIOD_NS - 1) / `PLLPD_CLK_PERIOD_NS)

`endif

// *** logic/pllpd_pkg.sv ***
// pllpd_pkg: types shared by the lock monitor files
// assumes: constants come from pllpd_defs.svh
`default_nettype none
package pllpd_pkg;

  typedef enum logic [1:0] {
    PLLPD_UNLOCKED = 2'b01,
    PLLPD_LOCKED   = 2'b10
  } pllpd_lock_type;

endpackage
`default_nettype wire

// *** logic/pllpd_sync.sv ***
// pllpd_sync: two-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to clk; only q is read downstream
`timescale 1ns/1ps
`default_nettype none
module pllpd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("pllpd_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// *** logic/pllpd_pfd.sv ***
// pllpd_pfd: three-state phase-frequency detector on sampled divider edges
// assumes: refEdge and mainEdge are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module pllpd_pfd (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic refEdge,
  input  wire logic mainEdge,
  output logic      pumpUpN,
  output logic      pumpDownN
);

  logic upNxt;
  logic downNxt;

  always_comb begin
    upNxt   = ~pumpUpN | refEdge;
    downNxt = ~pumpDownN | mainEdge;
    // both edges seen: reset both, so the pulses never overlap for long
    if (upNxt && downNxt) begin
      upNxt   = 1'b0;
      downNxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pumpUpN   <= 1'b1;
      pumpDownN <= 1'b1;
    end else begin
      pumpUpN   <= ~upNxt;
      pumpDownN <= ~downNxt;
    end
  end

endmodule
`default_nettype wire

// *** logic/pllpd_top.sv ***
// pllpd_top: phase detector, lock monitor, divider monitors and aux output
// assumes: divider outputs and programming pins are asynchronous to clk and
// toggle well below clk/4; apb master on clk; external pull-up on the lock pin
//
// Notes on behaviour
// - the reference divider output goes to its monitor pin unless a set enhancement bit stops it.
// - the main divider output goes to its monitor pin unless a set enhancement bit stops it.
// - an enhancement bit picks modulus select or raw prescaler output for the aux data pin.
// - enhancement bits act only while the enhancement-mode input is low.
// - down pulses low when the main divider edge leads the reference edge.
// - up pulses low when the reference divider edge leads the main edge.
// - the lock filter node is the nand of the up and down outputs.
// - the lock indicator is an open-drain inverted copy of the filtered lock node.
// - in lock the indicator floats; otherwise it drives low.
// - in serial mode with enhancement write high, each sclk rise shifts sdata in, msb first.
// - in parallel mode the eight data pins load the enhancement register on the write rise.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pllpd_defs.svh"
module pllpd_top #(
  parameter int LOCK_CYCLES = `PLLPD_LOCK_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`PLLPD_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  // divider and prescaler pins
  input  wire logic                      referenceInput,
  input  wire logic                      mainDivInput,
  input  wire logic                      modulusSelect,
  input  wire logic                      prescalerRaw,
  // programming pins
  input  wire logic                      enhModeN,
  input  wire logic                      serialMode,
  input  wire logic                      sclk,
  input  wire logic                      sdata,
  input  wire logic                      enhWrite,
  input  wire logic [`PLLPD_ENH_W-1:0]   pdata,
  // outputs to pins
  output logic                           refDivMonitor,
  output logic                           mainDivMonitor,
  output logic                           auxDataOut,
  output logic                           pumpUpN,
  output logic                           pumpDownN,
  output logic                           lockFilterNode,
  output logic                           lockIndicatorOut,
  output logic                           lockIndicatorOe
);

  localparam int SYNC_W = 9 + `PLLPD_ENH_W;
  localparam int CNT_W  = $clog2(LOCK_CYCLES + 1);

  generate
    if (LOCK_CYCLES < 1) begin : g_chk
      $error("pllpd_top: LOCK_CYCLES must be at least 1");
    end
  endgenerate

  logic [SYNC_W-1:0]        syncIn;
  logic [SYNC_W-1:0]        syncOut;
  logic                     refS;
  logic                     mainS;
  logic                     modSelS;
  logic                     prescS;
  logic                     enhNS;
  logic                     serialS;
  logic                     sclkS;
  logic                     sdataS;
  logic                     enhWrS;
  logic [`PLLPD_ENH_W-1:0]  pdataS;
  logic                     refDly_r;
  logic                     mainDly_r;
  logic                     sclkDly_r;
  logic                     enhWrDly_r;
  logic                     refEdge;
  logic                     mainEdge;
  logic                     sclkRise;
  logic                     enhWrRise;
  logic                     enhActive;
  logic [`PLLPD_ENH_W-1:0]  enh_r;
  logic                     enhLoad;
  logic [CNT_W-1:0]         lockCnt_r;
  pllpd_pkg::pllpd_lock_type lockState_r;
  logic                     locked;
  logic                     lockGain;
  logic                     lockLoss;
  logic [`PLLPD_IRQ_W-1:0]  irqStat_r;
  logic [`PLLPD_IRQ_W-1:0]  irqMask_r;
  logic [`PLLPD_IRQ_W-1:0]  irqSet;
  logic                     apbSetup;
  logic                     apbWrite;
  logic                     addrOk;
  logic [31:0]              rdNxt;

  // every divider and programming pin passes two flops before any logic reads it
  assign syncIn = {pdata, enhWrite, sdata, sclk, serialMode, enhModeN,
                   prescalerRaw, modulusSelect, mainDivInput, referenceInput};

  pllpd_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (syncIn),
    .q    (syncOut)
  );

  assign refS    = syncOut[0];
  assign mainS   = syncOut[1];
  assign modSelS = syncOut[2];
  assign prescS  = syncOut[3];
  assign enhNS   = syncOut[4];
  assign serialS = syncOut[5];
  assign sclkS   = syncOut[6];
  assign sdataS  = syncOut[7];
  assign enhWrS  = syncOut[8];
  assign pdataS  = syncOut[SYNC_W-1:9];

  // edge detectors on the synchronised copies
  always_ff @(posedge clk) begin
    if (!rstn) begin
      refDly_r   <= 1'b0;
      mainDly_r  <= 1'b0;
      sclkDly_r  <= 1'b0;
      enhWrDly_r <= 1'b0;
    end else begin
      refDly_r   <= refS;
      mainDly_r  <= mainS;
      sclkDly_r  <= sclkS;
      enhWrDly_r <= enhWrS;
    end
  end

  assign refEdge   = refS & ~refDly_r;
  assign mainEdge  = mainS & ~mainDly_r;
  assign sclkRise  = sclkS & ~sclkDly_r;
  assign enhWrRise = enhWrS & ~enhWrDly_r;

  // enhancement bits matter only with the mode input low
  assign enhActive = ~enhNS;

  // phase detector
  pllpd_pfd u_pfd (
    .clk       (clk),
    .rstn      (rstn),
    .refEdge   (refEdge),
    .mainEdge  (mainEdge),
    .pumpUpN   (pumpUpN),
    .pumpDownN (pumpDownN)
  );

  // enhancement register; pin loads win over a software write in the same cycle
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;
  assign enhLoad  = (serialS & enhWrS & sclkRise) | (~serialS & enhWrRise);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enh_r <= `PLLPD_ENH_RST;
    end else if (serialS && enhWrS && sclkRise) begin
      enh_r <= {enh_r[`PLLPD_ENH_W-2:0], sdataS};
    end else if (!serialS && enhWrRise) begin
      enh_r <= pdataS;
    end else if (apbWrite && !pslverr && paddr == `PLLPD_OFS_ENH) begin
      enh_r <= pwdata[`PLLPD_ENH_W-1:0];
    end
  end

  // monitor and aux pins, bit positions fixed in the defs header
  always_ff @(posedge clk) begin
    if (!rstn) begin
      refDivMonitor  <= 1'b0;
      mainDivMonitor <= 1'b0;
      auxDataOut     <= 1'b0;
    end else begin
      refDivMonitor  <= refS & ~(enhActive & enh_r[`PLLPD_ENH_REF_DIS]);
      mainDivMonitor <= mainS & ~(enhActive & enh_r[`PLLPD_ENH_MAIN_DIS]);
      // aux output defaults to modulus select when enhancement is off
      auxDataOut     <= (enhActive & enh_r[`PLLPD_ENH_AUX_SEL]) ? prescS : modSelS;
    end
  end

  // lock filter node: high while either pump pulse is active
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lockFilterNode <= 1'b0;
    end else begin
      lockFilterNode <= ~(pumpUpN & pumpDownN);
    end
  end

  // digital stand-in for the external capacitor: node must stay low
  // LOCK_CYCLES cycles; a single pump pulse drops lock at once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lockCnt_r   <= '0;
      lockState_r <= pllpd_pkg::PLLPD_UNLOCKED;
    end else begin
      case (lockState_r)
        pllpd_pkg::PLLPD_UNLOCKED: begin
          if (lockFilterNode) begin
            lockCnt_r <= '0;
          end else if (lockCnt_r == CNT_W'(LOCK_CYCLES - 1)) begin
            lockState_r <= pllpd_pkg::PLLPD_LOCKED;
          end else begin
            lockCnt_r <= lockCnt_r + 1'b1;
          end
        end
        pllpd_pkg::PLLPD_LOCKED: begin
          if (lockFilterNode) begin
            lockCnt_r   <= '0;
            lockState_r <= pllpd_pkg::PLLPD_UNLOCKED;
          end
        end
        default: begin
          lockCnt_r   <= '0;
          lockState_r <= pllpd_pkg::PLLPD_UNLOCKED;
        end
      endcase
    end
  end

  assign locked   = (lockState_r == pllpd_pkg::PLLPD_LOCKED);
  assign lockGain = (lockState_r == pllpd_pkg::PLLPD_UNLOCKED) && !lockFilterNode &&
                    (lockCnt_r == CNT_W'(LOCK_CYCLES - 1));
  assign lockLoss = locked && lockFilterNode;

  // open drain: output level is always low, enable pulls only when unlocked
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lockIndicatorOut <= 1'b0;
      lockIndicatorOe  <= 1'b1;
    end else begin
      lockIndicatorOut <= 1'b0;
      lockIndicatorOe  <= ~locked;
    end
  end

  // interrupts: sticky, write one to clear, a new event beats the clear
  assign irqSet = {enhLoad, lockLoss, lockGain};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqStat_r <= `PLLPD_IRQ_RST;
      irqMask_r <= `PLLPD_IRQ_RST;
    end else begin
      if (apbWrite && paddr == `PLLPD_OFS_IRQ_STAT) begin
        irqStat_r <= (irqStat_r & ~pwdata[`PLLPD_IRQ_W-1:0]) | irqSet;
      end else begin
        irqStat_r <= irqStat_r | irqSet;
      end
      if (apbWrite && paddr == `PLLPD_OFS_IRQ_MASK) begin
        irqMask_r <= pwdata[`PLLPD_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqStat_r | irqSet) & irqMask_r);
    end
  end

  // apb decode; answer is prepared in setup so pready is a flop
  always_comb begin
    addrOk = 1'b1;
    rdNxt  = 32'h0000_0000;
    case (paddr)
      `PLLPD_OFS_ENH: begin
        rdNxt[`PLLPD_ENH_W-1:0] = enh_r;
      end
      `PLLPD_OFS_STATUS: begin
        rdNxt[`PLLPD_ST_LOCKED]  = locked;
        rdNxt[`PLLPD_ST_NODE]    = lockFilterNode;
        rdNxt[`PLLPD_ST_UP_N]    = pumpUpN;
        rdNxt[`PLLPD_ST_DOWN_N]  = pumpDownN;
        rdNxt[`PLLPD_ST_ENH_ACT] = enhActive;
        rdNxt[`PLLPD_ST_SERIAL]  = serialS;
      end
      `PLLPD_OFS_IRQ_STAT: begin
        rdNxt[`PLLPD_IRQ_W-1:0] = irqStat_r;
      end
      `PLLPD_OFS_IRQ_MASK: begin
        rdNxt[`PLLPD_IRQ_W-1:0] = irqMask_r;
      end
      default: begin
        addrOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apbSetup) begin
      pready  <= 1'b1;
      pslverr <= ~addrOk;
      prdata  <= pwrite ? 32'h0000_0000 : rdNxt;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** bench/pllpd_checker.sv ***
// pllpd_checker: pin and bus relations of the lock monitor top
// assumes: bound to pllpd_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pllpd_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enhModeN,
  input wire logic referenceInput,
  input wire logic refDivMonitor,
  input wire logic pumpUpN,
  input wire logic pumpDownN,
  input wire logic lockFilterNode,
  input wire logic lockIndicatorOut,
  input wire logic lockIndicatorOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_node;
    $past(rstn) |-> lockFilterNode == !($past(pumpUpN) && $past(pumpDownN));
  endproperty
  a_node: assert property (p_node) else $error("lock node is not nand of pumps");
  property p_od;
    lockIndicatorOut == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("lock pin driven high");
  property p_unlock;
    lockFilterNode |-> ##[1:2] lockIndicatorOe;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock pin floats while node high");
  // release only after a quiet node, not on a glitch
  property p_lock;
    $fell(lockIndicatorOe) |-> !$past(lockFilterNode, 2) && !$past(lockFilterNode, 3);
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin released too early");
  property p_both;
    !pumpUpN && !pumpDownN |=> pumpUpN && pumpDownN;
  endproperty
  a_both: assert property (p_both) else $error("both pumps held low");
  property p_dn;
    $fell(pumpDownN) |-> pumpUpN;
  endproperty
  a_dn: assert property (p_dn) else $error("down pulse during up pulse");
  property p_up;
    $fell(pumpUpN) |-> pumpDownN;
  endproperty
  a_up: assert property (p_up) else $error("up pulse during down pulse");
  property p_mon;
    (enhModeN && rstn)[*5] |-> refDivMonitor == $past(referenceInput, 3);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor not following divider");
  property p_apb;
    psel && !penable |=> pready && !$past(pslverr);
  endproperty
  a_apb: assert property (p_apb) else $error("no ready one cycle after setup");
endmodule
bind pllpd_top pllpd_checker u_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .enhModeN(enhModeN), .referenceInput(referenceInput),
  .refDivMonitor(refDivMonitor), .pumpUpN(pumpUpN), .pumpDownN(pumpDownN),
  .lockFilterNode(lockFilterNode), .lockIndicatorOut(lockIndicatorOut),
  .lockIndicatorOe(lockIndicatorOe)
);
`default_nettype wire

// *** bench/pllpd_pump_model.sv ***
// pllpd_pump_model: charge pump activity and pulled-up lock pin
// assumes: open-drain lock pin with an external pull-up; pumps active low
`timescale 1ns/1ps
`default_nettype none
module pllpd_pump_model (
  input  wire logic pumpUpN,
  input  wire logic pumpDownN,
  input  wire logic lockIndicatorOut,
  input  wire logic lockIndicatorOe,
  output logic      lockPin,
  output logic      pumpBusy
);
  // pull-up wins whenever the device lets go of the pin
  assign lockPin  = lockIndicatorOe ? lockIndicatorOut : 1'b1;
  assign pumpBusy = !pumpUpN || !pumpDownN;
endmodule
`default_nettype wire

// *** bench/tb_pll_phase_detect_lock_monitor.sv ***
// tb_pll_phase_detect_lock_monitor: directed scenarios for the lock monitor
// assumes: pllpd_top with a short lock count, checker bound, pump model on pins
`timescale 1ns/1ps
`default_nettype none
`include "pllpd_defs.svh"
module tb_pll_phase_detect_lock_monitor;
  localparam int LOCKN = 4;
  logic                     clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [`PLLPD_ADDR_W-1:0] paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic                     refIn, mainIn, modSel, preRaw, enhModeN, serialMode;
  logic                     sclk, sdata, enhWrite, err, lockPin, busy;
  logic [7:0]               pdata;
  logic                     refMon, mainMon, auxOut, upN, downN, node, ldOut, ldOe;
  int                       numErrors, nTests, cyc;

  pllpd_top #(.LOCK_CYCLES(LOCKN)) u_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .referenceInput(refIn), .mainDivInput(mainIn),
    .modulusSelect(modSel), .prescalerRaw(preRaw), .enhModeN(enhModeN),
    .serialMode(serialMode), .sclk(sclk), .sdata(sdata), .enhWrite(enhWrite),
    .pdata(pdata), .refDivMonitor(refMon), .mainDivMonitor(mainMon),
    .auxDataOut(auxOut), .pumpUpN(upN), .pumpDownN(downN), .lockFilterNode(node),
    .lockIndicatorOut(ldOut), .lockIndicatorOe(ldOe)
  );
  pllpd_pump_model u_pump (
    .pumpUpN(upN), .pumpDownN(downN), .lockIndicatorOut(ldOut),
    .lockIndicatorOe(ldOe), .lockPin(lockPin), .pumpBusy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // values read right after the edge are the ones sampled at it
  // no retry limit here: only the bench timeout ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs;
    apb(1'b0, `PLLPD_OFS_ENH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PLLPD_OFS_STATUS, 32'h0);
    chk(rd, 32'h0d);
    chk(lockPin, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_00ff);
    chk({rd[0], err}, 2'b01);
  endtask

  task automatic t_irq;
    apb(1'b0, `PLLPD_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, `PLLPD_OFS_IRQ_MASK, 32'h1);
    waitc(3);
    chk(irq, 1'b1);
    apb(1'b1, `PLLPD_OFS_IRQ_STAT, 32'h1);
    waitc(3);
    chk(irq, 1'b0);
  endtask

  task automatic t_pfd(input logic refFirst);
    if (refFirst) refIn <= 1'b1;
    else mainIn <= 1'b1;
    // pump 3 cycles after the pin, node one later, unlock and enable two more
    waitc(8);
    chk({upN, downN}, refFirst ? 2'b01 : 2'b10);
    chk({node, lockPin, busy}, 3'b101);
    if (refFirst) mainIn <= 1'b1;
    else refIn <= 1'b1;
    waitc(6);
    chk({upN, downN}, 2'b11);
    refIn  <= 1'b0;
    mainIn <= 1'b0;
    waitc(LOCKN + 6);
    chk(lockPin, 1'b1);
    apb(1'b0, `PLLPD_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `PLLPD_OFS_IRQ_STAT, 32'h7);
  endtask

  task automatic t_par;
    enhModeN <= 1'b0;
    pdata    <= 8'h05;
    refIn    <= 1'b1;
    preRaw   <= 1'b1;
    waitc(4);
    enhWrite <= 1'b1;
    waitc(6);
    enhWrite <= 1'b0;
    apb(1'b0, `PLLPD_OFS_ENH, 32'h0);
    chk(rd, 32'h05);
    chk({refMon, auxOut}, 2'b01);
    apb(1'b0, `PLLPD_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, `PLLPD_OFS_IRQ_STAT, 32'h7);
    enhModeN <= 1'b1;
    modSel   <= 1'b1;
    preRaw   <= 1'b0;
    waitc(6);
    chk({refMon, auxOut}, 2'b11);
    mainIn <= 1'b1;
    waitc(6);
    refIn  <= 1'b0;
    mainIn <= 1'b0;
  endtask

  task automatic t_ser;
    logic [7:0] v;
    v = 8'h02;
    enhModeN   <= 1'b0;
    serialMode <= 1'b1;
    waitc(4);
    enhWrite <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sdata <= v[i];
      waitc(4);
      sclk <= 1'b1;
      waitc(4);
      sclk <= 1'b0;
    end
    waitc(4);
    enhWrite <= 1'b0;
    mainIn   <= 1'b1;
    waitc(6);
    apb(1'b0, `PLLPD_OFS_ENH, 32'h0);
    chk(rd, 32'h02);
    chk({mainMon, auxOut}, 2'b01);
    apb(1'b1, `PLLPD_OFS_ENH, 32'h0);
    waitc(3);
    chk(mainMon, 1'b1);
    refIn <= 1'b1;
    waitc(6);
    refIn  <= 1'b0;
    mainIn <= 1'b0;
  endtask

  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {refIn, mainIn, modSel, preRaw, serialMode, sclk, sdata, enhWrite} = '0;
    pdata = 8'h00;
    enhModeN = 1'b1;
    numErrors = 0;
    nTests = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    waitc(LOCKN + 6);
    t_regs();
    t_irq();
    t_pfd(1'b1);
    t_pfd(1'b0);
    t_par();
    t_ser();
    final_report();
  end
endmodule
`default_nettype wire
